/* hdl/sumul_top.sv */
// datapath of the signed-by-unsigned multiply family: decode, operand fetch, result placement
`include "sumul_defines.svh"

module sumul_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // instruction issue
    input wire logic INSN_VALID,
    input wire logic [23:0] INSN_WORD,
    input wire logic [15:0] CORE_CONTROL_REG,
    // working register file view, register n at bits 16n+15..16n
    input wire logic [255:0] WREG_FLAT,
    // data memory read for indirect source
    output logic MEM_RD,
    output logic [15:0] MEM_ADDR,
    input wire logic [15:0] MEM_RDATA,
    // source pointer writeback
    output logic PTR_WE,
    output logic [3:0] PTR_ADDR,
    output logic [15:0] PTR_DATA,
    // product into register pair
    output logic RES_WE,
    output logic [3:0] RES_ADDR,
    output logic [15:0] RES_LO,
    output logic [15:0] RES_HI,
    // accumulator load
    output logic ACC_WE,
    output logic ACC_SEL,
    output logic [39:0] ACC_DATA
);

    // ------------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------------
    // read one working register out of the flat view
    function automatic logic [15:0] wreg_read(input logic [255:0] regs, input logic [3:0] idx);
        wreg_read = regs[{idx, 4'h0} +: 16];
    endfunction

    // pointer value after the mode's update; pointers move a word at a time
    function automatic logic [15:0] ptr_next(input logic [15:0] ptr,
                                             input sumul_pkg::sumul_amode_t mode);
        case (mode)
            sumul_pkg::SUMUL_AM_POSTINC, sumul_pkg::SUMUL_AM_PREINC: begin
                ptr_next = ptr + `SUMUL_WORD_STEP;
            end
            sumul_pkg::SUMUL_AM_POSTDEC, sumul_pkg::SUMUL_AM_PREDEC: begin
                ptr_next = ptr - `SUMUL_WORD_STEP;
            end
            default: begin
                ptr_next = ptr;
            end
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    // only the opcode byte selects; there is no byte-size bit to look at
    wire logic opc_hit = INSN_VALID
        && (INSN_WORD[`SUMUL_OPC_MSB:`SUMUL_OPC_LSB] == `SUMUL_OPC_VAL);
    wire logic acc_tag = INSN_WORD[`SUMUL_ACCTAG_MSB:`SUMUL_ACCTAG_LSB]
        == `SUMUL_ACCTAG_VAL;
    wire logic lit_tag = INSN_WORD[`SUMUL_LITTAG_MSB:`SUMUL_LITTAG_LSB]
        == `SUMUL_LITTAG_VAL;
    // bit 15 must be clear except in the literal accumulator form, where either value is taken and the bit is not read
    wire logic form_ok = !INSN_WORD[`SUMUL_FORM_BIT] || (acc_tag && lit_tag);
    wire logic take = opc_hit && form_ok;
    wire sumul_pkg::sumul_amode_t amode =
        sumul_pkg::sumul_amode_t'(INSN_WORD[`SUMUL_P_MSB:`SUMUL_P_LSB]);
    wire logic [3:0] base_idx = INSN_WORD[`SUMUL_W_MSB:`SUMUL_W_LSB];
    wire logic [3:0] src_idx = INSN_WORD[`SUMUL_S_MSB:`SUMUL_S_LSB];
    wire logic [3:0] dst_idx = INSN_WORD[`SUMUL_D_MSB:`SUMUL_D_LSB];
    wire logic acc_pick = INSN_WORD[`SUMUL_ACCSEL_BIT];

    // ------------------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------------------
    // base always direct; source pointer read out of the same view
    wire logic [15:0] base_val = wreg_read(WREG_FLAT, base_idx);
    wire logic [15:0] src_ptr = wreg_read(WREG_FLAT, src_idx);
    wire logic [15:0] ptr_upd = ptr_next(src_ptr, amode);
    wire logic pre_mode = (amode == sumul_pkg::SUMUL_AM_PREINC)
        || (amode == sumul_pkg::SUMUL_AM_PREDEC);
    wire logic [15:0] eff_addr = pre_mode ? ptr_upd : src_ptr;
    wire logic mem_need = !lit_tag && (amode != sumul_pkg::SUMUL_AM_DIRECT);
    wire logic ptr_move = mem_need && (amode != sumul_pkg::SUMUL_AM_IND);
    wire logic [15:0] lit_val = {`SUMUL_LIT_PAD,
        INSN_WORD[`SUMUL_K_MSB:`SUMUL_K_LSB]};
    wire logic [15:0] src_now = lit_tag ? lit_val : src_ptr;
    // only accumulator forms look at the fraction bit; sign mode bits are never read
    wire logic frac_now = acc_tag
        && !CORE_CONTROL_REG[`SUMUL_IF_BIT];

    // ------------------------------------------------------------------------
    // first stage: decoded instruction and memory request
    // ------------------------------------------------------------------------
    logic s1_valid_ff;
    logic s1_acc_ff;
    logic s1_sel_ff;
    logic s1_mem_ff;
    logic s1_frac_ff;
    logic [3:0] s1_dst_ff;
    logic [15:0] s1_base_ff;
    logic [15:0] s1_src_ff;
    logic mem_rd_ff;
    logic [15:0] mem_addr_ff;
    logic ptr_we_ff;
    logic [3:0] ptr_addr_ff;
    logic [15:0] ptr_data_ff;

    // one new instruction may be taken every edge; nothing ever stalls
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s1_valid_ff <= 1'b0;
            s1_acc_ff <= 1'b0;
            s1_sel_ff <= 1'b0;
            s1_mem_ff <= 1'b0;
            s1_frac_ff <= 1'b0;
            s1_dst_ff <= 4'h0;
            s1_base_ff <= 16'h0000;
            s1_src_ff <= 16'h0000;
        end else begin
            s1_valid_ff <= take;
            s1_acc_ff <= acc_tag;
            s1_sel_ff <= acc_pick;
            s1_mem_ff <= mem_need;
            s1_frac_ff <= frac_now;
            s1_dst_ff <= dst_idx;
            s1_base_ff <= base_val;
            s1_src_ff <= src_now;
        end
    end

    // memory read and pointer update leave together, a cycle before the product
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= 16'h0000;
            ptr_we_ff <= 1'b0;
            ptr_addr_ff <= 4'h0;
            ptr_data_ff <= 16'h0000;
        end else begin
            mem_rd_ff <= take && mem_need;
            mem_addr_ff <= eff_addr;
            ptr_we_ff <= take && ptr_move;
            ptr_addr_ff <= src_idx;
            ptr_data_ff <= ptr_upd;
        end
    end

    // ------------------------------------------------------------------------
    // second stage: multiply and place the result
    // ------------------------------------------------------------------------
    wire logic [15:0] src_op = s1_mem_ff ? MEM_RDATA : s1_src_ff;
    logic [31:0] product;
    logic [39:0] acc_value;

    sumul_mult u_mult (
        .base_op(s1_base_ff),
        .src_op(src_op),
        .frac_mode(s1_frac_ff),
        .product(product),
        .acc_value(acc_value)
    );

    logic res_we_ff;
    logic [3:0] res_addr_ff;
    logic [15:0] res_lo_ff;
    logic [15:0] res_hi_ff;
    logic acc_we_ff;
    logic acc_sel_ff;
    logic [39:0] acc_data_ff;
    // no status flag path exists, so flags are left as they were
    wire logic nxt_res_we = s1_valid_ff && !s1_acc_ff;
    wire logic nxt_acc_we = s1_valid_ff && s1_acc_ff;

    // data registers load only with their strobe so idle outputs keep the last value
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            res_we_ff <= 1'b0;
            acc_we_ff <= 1'b0;
            res_addr_ff <= 4'h0;
            res_lo_ff <= 16'h0000;
            res_hi_ff <= 16'h0000;
            acc_sel_ff <= 1'b0;
            acc_data_ff <= 40'h00_0000_0000;
        end else begin
            res_we_ff <= nxt_res_we;
            acc_we_ff <= nxt_acc_we;
            if (nxt_res_we) begin
                res_addr_ff <= s1_dst_ff;
                res_lo_ff <= product[15:0];
                res_hi_ff <= product[31:16];
            end
            if (nxt_acc_we) begin
                acc_sel_ff <= s1_sel_ff;
                acc_data_ff <= acc_value;
            end
        end
    end

    // outputs straight from flip-flops
    assign MEM_RD = mem_rd_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign PTR_WE = ptr_we_ff;
    assign PTR_ADDR = ptr_addr_ff;
    assign PTR_DATA = ptr_data_ff;
    assign RES_WE = res_we_ff;
    assign RES_ADDR = res_addr_ff;
    assign RES_LO = res_lo_ff;
    assign RES_HI = res_hi_ff;
    assign ACC_WE = acc_we_ff;
    assign ACC_SEL = acc_sel_ff;
    assign ACC_DATA = acc_data_ff;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence seq_take_reg;
        take && !acc_tag;
    endsequence

    sequence seq_take_acc;
        take && acc_tag;
    endsequence

    sequence seq_take_lit_reg;
        take && !acc_tag && lit_tag;
    endsequence

    a_reg_form_writes: assert property (
        seq_take_reg |-> ##2 (RES_WE && !ACC_WE && RES_ADDR == $past(dst_idx, 2))
    ) else $error("register form did not write its pair two edges later");

    a_acc_form_loads: assert property (
        seq_take_acc |-> ##2 (ACC_WE && !RES_WE && ACC_SEL == $past(acc_pick, 2))
    ) else $error("accumulator form did not load the chosen accumulator");

    a_acc_sign_extend: assert property (
        ACC_WE |-> (ACC_DATA[39:33] == {7{ACC_DATA[32]}})
    ) else $error("accumulator value not sign extended through bit 39");

    a_lit_reg_value: assert property (
        seq_take_lit_reg |-> ##2 ($signed({RES_HI, RES_LO}) == $signed(
            $past(base_val, 2)) * $signed({27'h0, $past(INSN_WORD[4:0], 2)}))
    ) else $error("literal register form product wrong");

    a_reg_ignores_mode: assert property (
        (s1_valid_ff && !s1_acc_ff) |=> ($signed({RES_HI, RES_LO}) == $signed(
            $past(s1_base_ff)) * $signed({16'h0000, $past(src_op)}))
    ) else $error("register form product depends on more than its operands");

    a_acc_scaling: assert property (
        (s1_valid_ff && s1_acc_ff) |=> ($signed(ACC_DATA) == ($signed($past(s1_base_ff))
            * $signed({24'h000000, $past(src_op)})) * ($past(s1_frac_ff) ? 2 : 1))
    ) else $error("accumulator product scaling wrong");

    a_ptr_post_inc: assert property (
        (take && amode == sumul_pkg::SUMUL_AM_POSTINC && !lit_tag) |=>
            (PTR_WE && MEM_RD && PTR_DATA == MEM_ADDR + `SUMUL_WORD_STEP)
    ) else $error("post-increment pointer or address wrong");

    a_ptr_pre_dec: assert property (
        (take && amode == sumul_pkg::SUMUL_AM_PREDEC && !lit_tag) |=>
            (PTR_WE && MEM_RD && PTR_DATA == MEM_ADDR
             && PTR_DATA == $past(src_ptr) - `SUMUL_WORD_STEP)
    ) else $error("pre-decrement pointer or address wrong");

    a_direct_no_mem: assert property (
        (take && (lit_tag || amode == sumul_pkg::SUMUL_AM_DIRECT)) |=> (!MEM_RD && !PTR_WE)
    ) else $error("direct or literal source touched memory or pointer");

    a_ptr_post_dec: assert property (
        (take && amode == sumul_pkg::SUMUL_AM_POSTDEC) |=>
            (PTR_WE && MEM_RD && PTR_DATA == MEM_ADDR - `SUMUL_WORD_STEP)
    ) else $error("post-decrement pointer or address wrong");

    a_ptr_pre_inc: assert property (
        (take && amode == sumul_pkg::SUMUL_AM_PREINC) |=>
            (PTR_WE && MEM_RD && PTR_DATA == MEM_ADDR
             && PTR_DATA == $past(src_ptr) + `SUMUL_WORD_STEP)
    ) else $error("pre-increment pointer or address wrong");

    // plain indirect must read at the pointer and leave the pointer where it was
    a_ind_plain_read: assert property (
        (take && amode == sumul_pkg::SUMUL_AM_IND) |=>
            (MEM_RD && !PTR_WE && MEM_ADDR == $past(src_ptr))
    ) else $error("plain indirect read moved the pointer or used a wrong address");

    // a refused or absent word must leave every strobe of both stages low
    sequence seq_quiet_flow;
        (!MEM_RD && !PTR_WE) ##1 (!RES_WE && !ACC_WE);
    endsequence

    a_idle_quiet: assert property (
        !take |=> seq_quiet_flow
    ) else $error("strobe raised without an accepted instruction");

endmodule

/* hdl/sumul_defines.svh */
// opcode field positions, match values and fixed figures of the signed-by-unsigned multiplier
`ifndef SUMUL_DEFINES_SVH
`define SUMUL_DEFINES_SVH

// ----------------------------------------------------------------------------
// opcode match
// ----------------------------------------------------------------------------
`define SUMUL_OPC_MSB 23
`define SUMUL_OPC_LSB 16
`define SUMUL_OPC_VAL 8'hB9
`define SUMUL_FORM_BIT 15

// ----------------------------------------------------------------------------
// operand fields
// ----------------------------------------------------------------------------
`define SUMUL_W_MSB 14
`define SUMUL_W_LSB 11
`define SUMUL_D_MSB 10
`define SUMUL_D_LSB 7
`define SUMUL_ACCTAG_MSB 10
`define SUMUL_ACCTAG_LSB 8
`define SUMUL_ACCTAG_VAL 3'h7
`define SUMUL_ACCSEL_BIT 7
`define SUMUL_P_MSB 6
`define SUMUL_P_LSB 4
`define SUMUL_LITTAG_MSB 6
`define SUMUL_LITTAG_LSB 5
`define SUMUL_LITTAG_VAL 2'h3
`define SUMUL_K_MSB 4
`define SUMUL_K_LSB 0
`define SUMUL_S_MSB 3
`define SUMUL_S_LSB 0

// ----------------------------------------------------------------------------
// control bits and fixed values
// ----------------------------------------------------------------------------
`define SUMUL_IF_BIT 0
`define SUMUL_WORD_STEP 16'h0002
`define SUMUL_LIT_PAD 11'h000

`endif

/* hdl/sumul_pkg.sv */
// types shared by the signed-by-unsigned multiplier files
package sumul_pkg;

    // ------------------------------------------------------------------------
    // source addressing modes of the p field
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SUMUL_AM_DIRECT  = 3'h0,
        SUMUL_AM_IND     = 3'h1,
        SUMUL_AM_POSTDEC = 3'h2,
        SUMUL_AM_POSTINC = 3'h3,
        SUMUL_AM_PREDEC  = 3'h4,
        SUMUL_AM_PREINC  = 3'h5,
        SUMUL_AM_LIT0    = 3'h6,
        SUMUL_AM_LIT1    = 3'h7
    } sumul_amode_t;

    // destination selected by the A bit
    typedef enum logic {
        SUMUL_ACC_A = 1'b0,
        SUMUL_ACC_B = 1'b1
    } sumul_acc_t;

endpackage

/* hdl/sumul_mult.sv */
// 16x16 signed-by-unsigned multiplier with accumulator scaling and extension
module sumul_mult (
    // operands
    input wire logic [15:0] base_op,
    input wire logic [15:0] src_op,
    input wire logic frac_mode,
    // results
    output logic [31:0] product,
    output logic [39:0] acc_value
);

    // ------------------------------------------------------------------------
    // product
    // ------------------------------------------------------------------------
    // base widened as signed, source widened with a zero so it stays unsigned
    wire logic signed [16:0] op_a = {base_op[15], base_op};
    wire logic signed [16:0] op_b = {1'b0, src_op};
    wire logic signed [33:0] full = op_a * op_b;
    // the true product always fits 32 bits, the top two are copies of bit 31
    assign product = full[31:0];

    // ------------------------------------------------------------------------
    // accumulator value
    // ------------------------------------------------------------------------
    // fractional operands gain one bit of weight; integer ones keep their place
    wire logic [32:0] scaled = frac_mode ? {full[31:0], 1'b0} : {full[31], full[31:0]};
    assign acc_value = {{7{scaled[32]}}, scaled};

endmodule

/* verification/sumul_core_model.sv */
// behavioural register file and data memory standing in front of the multiplier
module sumul_core_model (
    // clock
    input wire logic clk,
    // register file view
    output logic [255:0] wreg_flat,
    // data memory read
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [15:0] mem_rdata,
    // pointer and result writebacks
    input wire logic ptr_we,
    input wire logic [3:0] ptr_addr,
    input wire logic [15:0] ptr_data,
    input wire logic res_we,
    input wire logic [3:0] res_addr,
    input wire logic [15:0] res_lo,
    input wire logic [15:0] res_hi
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] regs [16];
    logic [15:0] mem [65536];
    logic [15:0] last_ff = 16'hA5A5;

    // flat view of the sixteen working registers
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            wreg_flat[16*i +: 16] = regs[i];
        end
    end

    // an idle read bus shows the inverse of the last word, so stale data cannot pass
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_ff;

    // writebacks land on the edge after their strobe
    always @(posedge clk) begin
        if (mem_rd) begin
            last_ff <= mem[mem_addr];
        end
        if (ptr_we) begin
            regs[ptr_addr] <= ptr_data;
        end
        if (res_we) begin
            regs[res_addr] <= res_lo;
            regs[res_addr + 4'h1] <= res_hi;
        end
    end

    // setup helpers for the bench
    task automatic load(input logic [3:0] n, input logic [15:0] v);
        regs[n] = v;
    endtask

    task automatic load_mem(input logic [15:0] a, input logic [15:0] v);
        mem[a] = v;
    endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the signed-by-unsigned multiplier datapath
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [23:0] w;
        logic [15:0] cc;
        logic acc;
        logic [3:0] dst;
        logic [39:0] val;
        logic mrd;
        logic [15:0] ma;
        logic pwe;
        logic [15:0] pd;
    } sumul_row_t;

    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic INSN_VALID = 1'b0;
    logic [23:0] INSN_WORD = 24'h000000;
    logic [15:0] CORE_CONTROL_REG = 16'h0000;
    logic [255:0] WREG_FLAT;
    logic MEM_RD, PTR_WE, RES_WE, ACC_WE, ACC_SEL;
    logic [15:0] MEM_ADDR, MEM_RDATA, PTR_DATA, RES_LO, RES_HI;
    logic [3:0] PTR_ADDR, RES_ADDR;
    logic [39:0] ACC_DATA;
    int error_cnt = 0;
    int n_checks = 0;

    // pair destinations are even and below fourteen, cc sweeps mode bits
    sumul_row_t rows [13] = '{
        '{24'hB9057F, 16'hFFFE, 1'b0, 4'hA, 40'hFFF84000, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB91270, 16'h0001, 1'b0, 4'h4, 40'hFFFF2400, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB94319, 16'hFFFF, 1'b0, 4'h6, 40'hF1000000, 1'b1, 16'h178C, 1'b0, 16'h0},
        '{24'hB91253, 16'h0000, 1'b0, 4'h4, 40'hFFFA6A00, 1'b1, 16'h0282, 1'b1, 16'h0282},
        '{24'hB9053D, 16'hFFFE, 1'b0, 4'hA, 40'hFFFF4000, 1'b1, 16'h0400, 1'b1, 16'h0402},
        '{24'hB9052D, 16'h0001, 1'b0, 4'hA, 40'hFFFE4000, 1'b1, 16'h0402, 1'b1, 16'h0400},
        '{24'hB9054D, 16'hFFFF, 1'b0, 4'hA, 40'hFFFEC000, 1'b1, 16'h03FE, 1'b1, 16'h03FE},
        '{24'hB94708, 16'hFFFF, 1'b1, 4'h0, 40'hFFF1000000, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB94708, 16'hFFFE, 1'b1, 4'h0, 40'hFFE2000000, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB977E2, 16'hFFFF, 1'b1, 4'h1, 40'h0000000084, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB9077F, 16'hFFFE, 1'b1, 4'h0, 40'hFFFFF08000, 1'b0, 16'h0, 1'b0, 16'h0},
        '{24'hB94799, 16'h0001, 1'b1, 4'h1, 40'hFFF1000000, 1'b1, 16'h178C, 1'b0, 16'h0},
        '{24'hB94309, 16'h0000, 1'b0, 4'h6, 40'hFE874000, 1'b0, 16'h0, 1'b0, 16'h0}
    };
    logic [23:0] bad_words [3] = '{24'hB8057F, 24'hB9857F, 24'hB9C709};

    always #2.5 CLK = ~CLK;

    sumul_top i_dut (.CLK(CLK), .RSTN(RSTN), .INSN_VALID(INSN_VALID), .INSN_WORD(INSN_WORD),
        .CORE_CONTROL_REG(CORE_CONTROL_REG), .WREG_FLAT(WREG_FLAT), .MEM_RD(MEM_RD),
        .MEM_ADDR(MEM_ADDR), .MEM_RDATA(MEM_RDATA), .PTR_WE(PTR_WE), .PTR_ADDR(PTR_ADDR),
        .PTR_DATA(PTR_DATA), .RES_WE(RES_WE), .RES_ADDR(RES_ADDR), .RES_LO(RES_LO),
        .RES_HI(RES_HI), .ACC_WE(ACC_WE), .ACC_SEL(ACC_SEL), .ACC_DATA(ACC_DATA));

    sumul_core_model i_core (.clk(CLK), .wreg_flat(WREG_FLAT), .mem_rd(MEM_RD),
        .mem_addr(MEM_ADDR), .mem_rdata(MEM_RDATA), .ptr_we(PTR_WE), .ptr_addr(PTR_ADDR),
        .ptr_data(PTR_DATA), .res_we(RES_WE), .res_addr(RES_ADDR), .res_lo(RES_LO),
        .res_hi(RES_HI));

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // offer one word for exactly one taking edge
    task automatic issue(input logic [23:0] w, input logic [15:0] cc);
        INSN_VALID = 1'b1;
        INSN_WORD = w;
        CORE_CONTROL_REG = cc;
        @(posedge CLK);
        #1;
        INSN_VALID = 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog: the run needs about seventy cycles
    initial begin
        #10000;
        error_cnt++;
        finish_test();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        i_core.load(4'h0, 16'hC000);
        i_core.load(4'h2, 16'hF240);
        i_core.load(4'h3, 16'h0280);
        i_core.load(4'h8, 16'hF000);
        i_core.load(4'h9, 16'h178C);
        i_core.load(4'hD, 16'h0400);
        i_core.load(4'hE, 16'h0042);
        i_core.load_mem(16'h178C, 16'hF000);
        i_core.load_mem(16'h0282, 16'h0068);
        i_core.load_mem(16'h0400, 16'h0003);
        i_core.load_mem(16'h0402, 16'h0007);
        i_core.load_mem(16'h03FE, 16'h0005);
        repeat (12) @(posedge CLK);
        #1;
        RSTN = 1'b1;
        // table of forms and addressing modes, one instruction in flight at a time
        for (int i = 0; i < 13; i++) begin
            // issue returns just after the taking edge, while read and pointer strobes stand
            issue(rows[i].w, rows[i].cc);
            chk(MEM_RD, rows[i].mrd);
            chk(PTR_WE, rows[i].pwe);
            if (rows[i].mrd) chk(MEM_ADDR, rows[i].ma);
            if (rows[i].pwe) chk({PTR_ADDR, PTR_DATA}, {rows[i].w[3:0], rows[i].pd});
            @(posedge CLK);
            #1;
            chk({RES_WE, ACC_WE}, {~rows[i].acc, rows[i].acc});
            if (rows[i].acc) begin
                chk({ACC_SEL, ACC_DATA}, {rows[i].dst[0], rows[i].val});
                chk(ACC_DATA, rows[i].val);
            end else begin
                chk({RES_ADDR, RES_HI, RES_LO}, {rows[i].dst, rows[i].val[31:0]});
                chk(RES_HI, rows[i].val[31:16]);
            end
            @(posedge CLK);
            #1;
        end
        // foreign opcode and malformed forms raise no strobe at all
        foreach (bad_words[j]) begin
            issue(bad_words[j], 16'h0001);
            repeat (3) begin
                chk({MEM_RD, PTR_WE, RES_WE, ACC_WE}, 4'h0);
                @(posedge CLK);
                #1;
            end
        end
        // back-to-back issue, one result per cycle
        INSN_VALID = 1'b1;
        INSN_WORD = rows[0].w;
        @(posedge CLK);
        #1;
        INSN_WORD = rows[1].w;
        @(posedge CLK);
        #1;
        INSN_VALID = 1'b0;
        chk({RES_WE, RES_ADDR, RES_HI, RES_LO}, {1'b1, 4'hA, 32'hFFF84000});
        @(posedge CLK);
        #1;
        chk({RES_WE, RES_ADDR, RES_HI, RES_LO}, {1'b1, 4'h4, 32'hFFFF2400});
        // reset in mid-flight drops the pending accumulator load
        issue(rows[7].w, rows[7].cc);
        RSTN = 1'b0;
        #1;
        chk({ACC_WE, ACC_DATA, RES_WE}, 42'h0);
        @(posedge CLK);
        #1;
        RSTN = 1'b1;
        @(posedge CLK);
        #1;
        chk({ACC_WE, ACC_DATA, RES_WE}, 42'h0);
        chk({MEM_RD, PTR_WE}, 2'h0);
        finish_test();
    end
endmodule
